// >>> rtl/bst_fsm.v
// Standard sixteen-state TAP controller
`timescale 1ns/10ps
`default_nettype none
module bst_fsm
(
    // Clock and reset
    input wire i_clk_sys,
    input wire i_rst_b,
    // Rising TCK event and TMS level
    input wire i_tck_rise,
    input wire i_tms,
    // Current state
    output wire [3:0] o_state
);
    // State codes
    localparam ST_RESET = 4'h0;
    localparam ST_IDLE = 4'h1;
    localparam ST_SEL_DR = 4'h2;
    localparam ST_CAP_DR = 4'h3;
    localparam ST_SH_DR = 4'h4;
    localparam ST_EX1_DR = 4'h5;
    localparam ST_PA_DR = 4'h6;
    localparam ST_EX2_DR = 4'h7;
    localparam ST_UP_DR = 4'h8;
    localparam ST_SEL_IR = 4'h9;
    localparam ST_CAP_IR = 4'ha;
    localparam ST_SH_IR = 4'hb;
    localparam ST_EX1_IR = 4'hc;
    localparam ST_PA_IR = 4'hd;
    localparam ST_EX2_IR = 4'he;
    localparam ST_UP_IR = 4'hf;
    reg [3:0] state_q; // Present state
    reg [3:0] state_d; // Next state
    // ----------------------------------------
    // Next state from TMS
    // ----------------------------------------
    always @*
    begin
        case (state_q)
            ST_RESET: state_d = i_tms ? ST_RESET : ST_IDLE;
            ST_IDLE: state_d = i_tms ? ST_SEL_DR : ST_IDLE;
            ST_SEL_DR: state_d = i_tms ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: state_d = i_tms ? ST_EX1_DR : ST_SH_DR;
            ST_SH_DR: state_d = i_tms ? ST_EX1_DR : ST_SH_DR;
            ST_EX1_DR: state_d = i_tms ? ST_UP_DR : ST_PA_DR;
            ST_PA_DR: state_d = i_tms ? ST_EX2_DR : ST_PA_DR;
            ST_EX2_DR: state_d = i_tms ? ST_UP_DR : ST_SH_DR;
            ST_UP_DR: state_d = i_tms ? ST_SEL_DR : ST_IDLE;
            ST_SEL_IR: state_d = i_tms ? ST_RESET : ST_CAP_IR;
            ST_CAP_IR: state_d = i_tms ? ST_EX1_IR : ST_SH_IR;
            ST_SH_IR: state_d = i_tms ? ST_EX1_IR : ST_SH_IR;
            ST_EX1_IR: state_d = i_tms ? ST_UP_IR : ST_PA_IR;
            ST_PA_IR: state_d = i_tms ? ST_EX2_IR : ST_PA_IR;
            ST_EX2_IR: state_d = i_tms ? ST_UP_IR : ST_SH_IR;
            ST_UP_IR: state_d = i_tms ? ST_SEL_DR : ST_IDLE;
            default: state_d = ST_RESET;
        endcase
    end
    // ----------------------------------------
    // Advance on rising TCK only
    // ----------------------------------------
    always @(posedge i_clk_sys or negedge i_rst_b)
    begin
        if (!i_rst_b)
            state_q <= ST_RESET;
        else if (i_tck_rise)
            state_q <= state_d;
    end
    assign o_state = state_q;
endmodule // bst_fsm
`default_nettype wire

// >>> rtl/bst_map.vh
// Constants for the boundary scan test access port
// How it works
// - IR 8, bypass 1, ID 32, boundary 113 bits
// - ID bit 0 always reads one
// - ID bits 11:1 hold manufacturer code
// - ID bits 31:28 die revision, width code
// - Extest captures ring, boundary chain selected
// - Sample/preload captures ring, boundary chain selected
// - ID code loads ID, ID selected
// - Clamp selects bypass, outputs from boundary
// - High-Z selects bypass, outputs floated
// - Bypass code selects one-bit bypass
// - Unused boundary cells read back zero
// - Sample/preload snapshots balls in capture-DR
`ifndef BST_MAP_VH
`define BST_MAP_VH
// ----------------------------------------
// Register lengths
// ----------------------------------------
`define BST_IR_LEN 8
`define BST_ID_LEN 32
`define BST_BSR_LEN 113
// ----------------------------------------
// Instruction codes
// ----------------------------------------
`define BST_OP_EXTEST 8'h00
`define BST_OP_IDCODE 8'h21
`define BST_OP_SAMPLE 8'h05
`define BST_OP_CLAMP 8'h07
`define BST_OP_HIGHZ 8'h03
`define BST_OP_BYPASS 8'hff
// ----------------------------------------
// Identification field positions
// ----------------------------------------
`define BST_ID_PRESENT_BIT 0
`define BST_ID_MFR_LSB 1
`define BST_ID_MFR_MSB 11
`define BST_ID_DEV_LSB 12
`define BST_ID_DEV_MSB 27
`define BST_ID_REV_LSB 28
`define BST_ID_REV_MSB 31
// Instruction register capture pattern
`define BST_IR_CAPTURE 8'h01
`endif

// >>> rtl/bst_sync.v
// Two-flop synchroniser for pin inputs
`timescale 1ns/10ps
`default_nettype none
module bst_sync
(
    // Clock and reset
    input wire i_clk_sys,
    input wire i_rst_b,
    // Asynchronous level
    input wire i_async,
    // Synchronised level
    output wire o_sync
);
    reg meta_q; // First stage, read only by second
    reg sync_q; // Second stage
    // ----------------------------------------
    // Two flops
    // ----------------------------------------
    always @(posedge i_clk_sys or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end
        else
        begin
            meta_q <= i_async;
            sync_q <= meta_q;
        end
    end
    assign o_sync = sync_q;
endmodule // bst_sync
`default_nettype wire

// >>> rtl/bst_tap.v
// Boundary scan test access port, top level
`timescale 1ns/10ps
`default_nettype none
`include "bst_map.vh"
module bst_tap
#(
    parameter BSR_LEN = `BST_BSR_LEN,
    // Arbitrary neutral identity values
    parameter [10:0] MFR_CODE = 11'h2aa,
    parameter [15:0] DEVICE_CODE = 16'h1234,
    parameter [1:0] DIE_REVISION_CODE = 2'h0,
    parameter [1:0] WIDTH_CODE = 2'h0,
    // Cells tied to a ball; others read zero
    parameter [BSR_LEN-1:0] USED_CELLS = {BSR_LEN{1'b1}}
)
(
    // Clock and reset
    input wire i_clk_sys,
    input wire i_rst_b,
    // Test pins from the board controller
    input wire i_tck,
    input wire i_tms,
    input wire i_tdi,
    output wire o_tdo,
    output wire o_tdo_oe_b,
    // Ball values seen by the I/O ring
    input wire [BSR_LEN-1:0] i_ring,
    // Ball control towards the I/O ring
    output wire [BSR_LEN-1:0] o_ring_data,
    output wire o_ring_override,
    output wire o_ring_hiz,
    // Current instruction
    output wire [7:0] o_instr
);
    // TAP state codes, matching the controller
    localparam ST_RESET = 4'h0;
    localparam ST_CAP_DR = 4'h3;
    localparam ST_SH_DR = 4'h4;
    localparam ST_UP_DR = 4'h8;
    localparam ST_CAP_IR = 4'ha;
    localparam ST_SH_IR = 4'hb;
    localparam ST_UP_IR = 4'hf;
    localparam IRL = `BST_IR_LEN;
    localparam IDL = `BST_ID_LEN;

    // ----------------------------------------
    // Timing overview
    // ----------------------------------------
    // All test pins sampled by the system clock
    // Each pin passes two flops before use
    // TCK edge seen about three clocks late
    // TMS and TDI delayed by the same amount
    // Hence both stay aligned with the seen edge
    // TCK high and low need three clocks each
    // Slower system clock would miss TCK edges
    // TDO moves one clock after a seen fall
    // TDO then held until the next seen fall
    // Enable low only across the shift states
    // TDO not floated; enable goes to the pad
    // Ring snapshot also two flops deep
    // Balls must settle before Capture-DR
    // A moving ball may capture either level
    // No state besides the TAP is kept here

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    wire tck_s; // Synchronised TCK
    wire tms_s; // Synchronised TMS
    wire tdi_s; // Synchronised TDI
    bst_sync u_sync_tck (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_async(i_tck),
        .o_sync(tck_s));
    bst_sync u_sync_tms (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_async(i_tms),
        .o_sync(tms_s));
    bst_sync u_sync_tdi (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_async(i_tdi),
        .o_sync(tdi_s));

    // Ring snapshot, two flops per ball
    // Bits may settle on different clocks
    // Only a stable ring gives a clean capture
    reg [BSR_LEN-1:0] ring_m_q; // First stage
    reg [BSR_LEN-1:0] ring_s_q; // Second stage
    always @(posedge i_clk_sys or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            ring_m_q <= {BSR_LEN{1'b0}};
            ring_s_q <= {BSR_LEN{1'b0}};
        end
        else
        begin
            ring_m_q <= i_ring;
            ring_s_q <= ring_m_q;
        end
    end

    // ----------------------------------------
    // TCK edge detection
    // ----------------------------------------
    // Reset value matches the idle low TCK
    // Hence no false edge right after reset
    // Edge events last exactly one system clock
    reg tck_prev_q; // Previous TCK level
    always @(posedge i_clk_sys or negedge i_rst_b)
    begin
        if (!i_rst_b)
            tck_prev_q <= 1'b0;
        else
            tck_prev_q <= tck_s;
    end
    wire tck_rise = tck_s & ~tck_prev_q; // Rising edge event
    wire tck_fall = ~tck_s & tck_prev_q; // Falling edge event

    // ----------------------------------------
    // TAP controller
    // ----------------------------------------
    wire [3:0] state; // Present TAP state
    bst_fsm u_fsm (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_tck_rise(tck_rise),
        .i_tms(tms_s), .o_state(state));

    // ----------------------------------------
    // Instruction register
    // ----------------------------------------
    reg [IRL-1:0] ir_sh_q; // Shift stage
    reg [IRL-1:0] ir_q; // Active instruction
    always @(posedge i_clk_sys or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            ir_sh_q <= {IRL{1'b0}};
            ir_q <= `BST_OP_IDCODE;
        end
        else if (tck_rise)
        begin
            case (state)
                ST_RESET:
                begin
                    // Reset selects ID
                    ir_q <= `BST_OP_IDCODE;
                end
                ST_CAP_IR:
                begin
                    // Fixed pattern, low bit out first
                    ir_sh_q <= `BST_IR_CAPTURE;
                end
                ST_SH_IR:
                begin
                    // LSB first towards TDO
                    ir_sh_q <= {tdi_s, ir_sh_q[IRL-1:1]};
                end
                ST_UP_IR:
                begin
                    // New instruction takes effect
                    ir_q <= ir_sh_q;
                end
                default:
                begin
                    // Hold active instruction
                    ir_q <= ir_q;
                end
            endcase
        end
    end

    // ----------------------------------------
    // Instruction effects
    // ----------------------------------------
    // Extest: boundary chain, balls untouched
    // Sample/preload: boundary chain, balls untouched
    // ID code: identification register
    // Clamp: bypass, balls from update latches
    // High-Z: bypass, balls floated
    // Bypass: one-bit bypass register
    // Any other code falls back to bypass
    // Instruction decode
    wire op_extest = (ir_q == `BST_OP_EXTEST);
    wire op_sample = (ir_q == `BST_OP_SAMPLE);
    wire op_idcode = (ir_q == `BST_OP_IDCODE);
    wire op_clamp = (ir_q == `BST_OP_CLAMP);
    wire op_highz = (ir_q == `BST_OP_HIGHZ);
    // Boundary chain selected by Extest and Sample/preload
    wire sel_bsr = op_extest | op_sample;
    // ID selected by ID code; codes selecting neither chain use bypass
    wire sel_id = op_idcode;

    // ----------------------------------------
    // Identification value
    // ----------------------------------------
    wire [IDL-1:0] id_value;
    assign id_value[`BST_ID_PRESENT_BIT] = 1'b1;
    assign id_value[`BST_ID_MFR_MSB:`BST_ID_MFR_LSB] = MFR_CODE;
    assign id_value[`BST_ID_DEV_MSB:`BST_ID_DEV_LSB] = DEVICE_CODE;
    assign id_value[`BST_ID_REV_MSB:`BST_ID_REV_LSB] =
        {DIE_REVISION_CODE, WIDTH_CODE};

    // ----------------------------------------
    // Data registers
    // ----------------------------------------
    reg bypass_q; // One-bit bypass
    reg [IDL-1:0] id_sh_q; // ID shift stage
    reg [BSR_LEN-1:0] bsr_q; // Boundary shift stage
    reg [BSR_LEN-1:0] bsr_upd_q; // Boundary update latches
    always @(posedge i_clk_sys or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            bypass_q <= 1'b0;
            id_sh_q <= {IDL{1'b0}};
            bsr_q <= {BSR_LEN{1'b0}};
            bsr_upd_q <= {BSR_LEN{1'b0}};
        end
        else if (tck_rise)
        begin
            case (state)
                ST_CAP_DR:
                begin
                    // Bypass always captures zero
                    // Unused cells capture zero via the mask
                    bypass_q <= 1'b0;
                    if (sel_id)
                        id_sh_q <= id_value;
                    if (sel_bsr)
                        bsr_q <= ring_s_q & USED_CELLS;
                end
                ST_SH_DR:
                begin
                    // All chains shift LSB first
                    bypass_q <= tdi_s;
                    if (sel_id)
                        id_sh_q <= {tdi_s, id_sh_q[IDL-1:1]};
                    // No mask here: bits must pass unused cells intact
                    // Masking would zero every bit above an unused cell
                    if (sel_bsr)
                        bsr_q <= {tdi_s, bsr_q[BSR_LEN-1:1]};
                end
                ST_UP_DR:
                begin
                    if (sel_bsr)
                        bsr_upd_q <= bsr_q; // Preload for later clamp
                end
                default:
                begin
                    bypass_q <= bypass_q;
                end
            endcase
        end
    end

    // ----------------------------------------
    // Serial output mux
    // ----------------------------------------
    reg tdo_bit; // Bit presented this shift
    always @*
    begin
        if (state == ST_SH_IR)
        begin
            tdo_bit = ir_sh_q[0]; // Instruction scan
        end
        else if (sel_bsr)
        begin
            tdo_bit = bsr_q[0]; // Boundary chain
        end
        else if (sel_id)
        begin
            tdo_bit = id_sh_q[0]; // Identification
        end
        else
        begin
            tdo_bit = bypass_q;
        end
    end
    wire shifting = (state == ST_SH_IR) || (state == ST_SH_DR);

    // TDO retimed on falling TCK
    reg tdo_q; // Output data
    reg tdo_oe_b_q; // Output enable, low drives
    always @(posedge i_clk_sys or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            tdo_q <= 1'b0;
            tdo_oe_b_q <= 1'b1;
        end
        else if (tck_fall)
        begin
            tdo_q <= tdo_bit;
            tdo_oe_b_q <= ~shifting;
        end
    end
    assign o_tdo = tdo_q;
    assign o_tdo_oe_b = tdo_oe_b_q;

    // ----------------------------------------
    // Ball control
    // ----------------------------------------
    // Update latches feed the balls when clamped
    // Override and float come from the decode alone
    // Extest and Sample/preload leave balls untouched
    // Instruction also visible for the ring logic
    assign o_ring_data = bsr_upd_q;
    assign o_ring_override = op_clamp;
    assign o_ring_hiz = op_highz;
    assign o_instr = ir_q;
endmodule // bst_tap
`default_nettype wire

// >>> verification/boundary_scan_tap_tb.sv
// Self-checking bench for the test access port
`timescale 1ns/10ps
`default_nettype none
module boundary_scan_tap_tb;
    // Cells 0 and 2 have no ball
    localparam logic [112:0] USED = ~113'h5;
    logic i_clk_sys = 1'b0;
    logic i_rst_b = 1'b0;
    logic [112:0] ring = '0;
    wire tck, tms, tdi, tdo, oe_b, ovr, hiz;
    wire [112:0] rdata;
    wire [7:0] instr;
    int error_cnt = 0;
    int compares = 0;
    // Six defined codes, sample/preload again last
    logic [7:0] codes [7] = '{8'h00, 8'h05, 8'h07, 8'h03, 8'hff, 8'h21, 8'h05};

    // 100 MHz system clock
    always #5 i_clk_sys = ~i_clk_sys;

    // Identity values are arbitrary
    bst_tap #(.DIE_REVISION_CODE(2'h1), .WIDTH_CODE(2'h2), .USED_CELLS(USED)) u_dut (
        .i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_tck(tck), .i_tms(tms), .i_tdi(tdi),
        .o_tdo(tdo), .o_tdo_oe_b(oe_b), .i_ring(ring), .o_ring_data(rdata),
        .o_ring_override(ovr), .o_ring_hiz(hiz), .o_instr(instr));
    bst_jtag_host u_host (.i_clk_sys(i_clk_sys), .i_tdo(tdo), .o_tck(tck), .o_tms(tms),
        .o_tdi(tdi));

    // Count and report one comparison
    task automatic check(input logic [127:0] got, input logic [127:0] exp, input string what);
    begin
        compares++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("mismatch at %0t: %s", $time, what);
        end
    end
    endtask

    // Verdict and end of run
    task automatic results();
    begin
        $display("errors %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    end
    endtask

    // Scan length per code, four bits for the bypass-path codes
    function automatic int len_of(input logic [7:0] code);
        if (code == 8'h00 || code == 8'h05)
            return 113;
        return (code == 8'h21) ? 32 : 4;
    endfunction

    // Expected scan-out per code
    function automatic logic [127:0] exp_dr(input logic [7:0] code, input logic [127:0] din);
        if (code == 8'h00 || code == 8'h05)
            return 128'(ring & USED);
        if (code == 8'h21)
            return {96'h0, 2'h1, 2'h2, 16'h1234, 11'h2aa, 1'b1};
        return {din[126:0], 1'b0} & 128'hf;
    endfunction

    // Hang guard
    initial
    begin
        repeat (30000) @(posedge i_clk_sys);
        error_cnt++;
        $display("mismatch at %0t: watchdog expired", $time);
        results();
    end

    // Main sequence
    initial
    begin
        logic [127:0] din, dout, upd;
        logic [7:0] code;
        void'($urandom(32'hf21a));
        upd = '0;
        repeat (16) @(posedge i_clk_sys);
        i_rst_b <= 1'b1;
        repeat (4) @(posedge i_clk_sys);
        check(128'(instr), 128'h21, "reset instruction");
        u_host.nav(1'b0);
        for (int k = 0; k < 7; k++)
        begin
            code = codes[k];
            din = {$urandom, $urandom, $urandom, $urandom};
            ring <= din[112:0];
            // Only the six defined codes are ever loaded
            u_host.scan(1'b1, 8, 128'(code), dout);
            check(dout, 128'h01, "ir capture");
            check(128'(instr), 128'(code), "instruction");
            check(128'(ovr), 128'(code == 8'h07), "override");
            check(128'(hiz), 128'(code == 8'h03), "hiz");
            din = {$urandom, $urandom, $urandom, $urandom};
            u_host.scan(1'b0, len_of(code), din, dout);
            check(dout, exp_dr(code, din), "scan out");
            check(128'(oe_b), 128'h1, "tdo released");
            if (code == 8'h00 || code == 8'h05)
                upd = din & 128'(USED);
            check(128'(rdata & USED), upd, "ball latches");
        end
        repeat (5) u_host.nav(1'b1);
        check(128'(instr), 128'h21, "tms reset");
        results();
    end
endmodule // boundary_scan_tap_tb
`default_nettype wire

// >>> verification/bst_jtag_host.sv
// Board-side scan controller model driving the test pins
`timescale 1ns/10ps
`default_nettype none
module bst_jtag_host
(
    // System clock paces the pins
    input wire logic i_clk_sys,
    // Serial data from the device
    input wire logic i_tdo,
    // Test pins towards the device
    output logic o_tck,
    output logic o_tms,
    output logic o_tdi
);
    // Toggling pattern for the unused data line
    logic idle_q = 1'b0;

    // Pins idle with TCK standing low
    initial
    begin
        o_tck = 1'b0;
        o_tms = 1'b1;
        o_tdi = 1'b0;
    end

    // One TCK period: pins set while low, TDO taken before rise
    task automatic step(input logic tms, input logic tdi, output logic tdo);
    begin
        @(posedge i_clk_sys);
        o_tms <= tms;
        o_tdi <= tdi;
        repeat (8) @(posedge i_clk_sys);
        tdo = i_tdo;
        o_tck <= 1'b1;
        repeat (8) @(posedge i_clk_sys);
        o_tck <= 1'b0;
    end
    endtask

    // Move the state machine, data line carries no payload
    task automatic nav(input logic tms);
        logic d;
    begin
        idle_q = ~idle_q;
        step(tms, idle_q, d);
    end
    endtask

    // Scan one register from Idle back to Idle, LSB first
    task automatic scan(input logic ir, input int n, input logic [127:0] din,
                        output logic [127:0] dout);
    begin
        dout = '0;
        nav(1'b1);
        if (ir)
            nav(1'b1);
        nav(1'b0);
        nav(1'b0);
        for (int i = 0; i < n; i++)
            step(i == n - 1, din[i], dout[i]);
        nav(1'b1);
        nav(1'b0);
    end
    endtask
endmodule // bst_jtag_host
`default_nettype wire

// >>> verification/bst_tap_sva.sv
// Checker for the test access port outputs
`timescale 1ns/10ps
`default_nettype none
module bst_tap_sva
#(
    parameter BSR_LEN = 113
)
(
    // Clock, reset and test clock pin
    input wire i_clk_sys,
    input wire i_rst_b,
    input wire i_tck,
    // Serial output pair
    input wire o_tdo,
    input wire o_tdo_oe_b,
    // Ball control and instruction
    input wire [BSR_LEN-1:0] o_ring_data,
    input wire o_ring_override,
    input wire o_ring_hiz,
    input wire [7:0] o_instr
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_b);

    a_hiz_decode: assert property (o_ring_hiz == (o_instr == 8'h03))
        else $error("hiz flag disagrees with instruction");
    a_clamp_decode: assert property (o_ring_override == (o_instr == 8'h07))
        else $error("override flag disagrees with instruction");
    a_clamp_hold: assert property (o_ring_override |=> $stable(o_ring_data))
        else $error("ball data moved while clamped");
    a_extest_quiet: assert property ((o_instr == 8'h00) |-> !o_ring_override && !o_ring_hiz)
        else $error("balls disturbed under extest");
    a_ring_update: assert property ($changed(o_ring_data) |-> o_instr inside {8'h00, 8'h05})
        else $error("ball latches changed under wrong instruction");
    a_tdo_on_fall: assert property ($changed(o_tdo) |-> !$past(i_tck) && !$past(i_tck, 2))
        else $error("tdo changed while tck high");
    a_oe_on_fall: assert property ($changed(o_tdo_oe_b) |-> !$past(i_tck) && !$past(i_tck, 2))
        else $error("tdo enable changed while tck high");
    a_tdo_holds: assert property ($changed(o_tdo) |=> $stable(o_tdo) [*8])
        else $error("tdo did not hold");
    a_oe_low_span: assert property ($fell(o_tdo_oe_b) |=> !o_tdo_oe_b [*8])
        else $error("tdo enable too short");
endmodule // bst_tap_sva
bind bst_tap bst_tap_sva #(.BSR_LEN(BSR_LEN)) u_sva (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b),
    .i_tck(i_tck), .o_tdo(o_tdo), .o_tdo_oe_b(o_tdo_oe_b), .o_ring_data(o_ring_data),
    .o_ring_override(o_ring_override), .o_ring_hiz(o_ring_hiz), .o_instr(o_instr));
`default_nettype wire
